// File: bench/idp_chk_sva.sv
// bus-port assertions for the pointer unit
`timescale 1ns/1ps
module idp_chk (
	input wire mclk,
	input wire rst,
	input wire s_axi_awvalid,
	input wire s_axi_awready,
	input wire s_axi_wvalid,
	input wire s_axi_wready,
	input wire s_axi_bvalid,
	input wire [7:0] s_axi_araddr,
	input wire s_axi_arvalid,
	input wire s_axi_arready,
	input wire [31:0] s_axi_rdata,
	input wire [1:0] s_axi_rresp,
	input wire s_axi_rvalid
);
	default clocking cb @(posedge mclk); endclocking
	default disable iff (rst);
	sequence s_ar;
		s_axi_arvalid && s_axi_arready;
	endsequence
	sequence s_wr;
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
	endsequence
	a_read_answer: assert property (s_ar |=> s_axi_rvalid)
		else $error("read not answered");
	a_write_answer: assert property (s_wr |-> ##[1:3] s_axi_bvalid)
		else $error("write not answered");
	a_high_zero: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
		else $error("upper read bits set");
	a_refuse_addr: assert property (s_ar ##0 s_axi_araddr[7] |=>
		s_axi_rresp == 2'h2 && s_axi_rdata == 32'h0)
		else $error("bad address not refused");
	a_refuse_mode: assert property (s_ar ##0 (s_axi_araddr[6:5] != 2'h0 &&
		s_axi_araddr[4:2] > 3'h4) |=> s_axi_rresp == 2'h2)
		else $error("bad mode not refused");
	a_read_single: assert property (s_axi_rvalid |-> !s_axi_arready)
		else $error("second read accepted");
	a_wr_busy: assert property (s_wr |=> !s_axi_awready && !s_axi_wready)
		else $error("write channel not held");
	a_okay_store: assert property (s_ar ##0 s_axi_araddr < 8'h20 |=>
		s_axi_rresp == 2'h0)
		else $error("stored register refused");
endmodule
bind idp_pointer_unit idp_chk idp_chk_inst (.mclk, .rst, .s_axi_awvalid,
	.s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid,
	.s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
	.s_axi_rresp, .s_axi_rvalid);

// File: bench/idp_core.sv
// core-side register bus master for the pointer unit
`timescale 1ns/1ps
module idp_core (
	input wire mclk,
	output reg [7:0] awa,
	output reg awv,
	input wire awr,
	output reg [31:0] wd,
	output reg wv,
	input wire wr_r,
	input wire bv,
	input wire [1:0] br,
	output reg [7:0] ara,
	output reg arv,
	input wire arr,
	input wire [31:0] rdat,
	input wire [1:0] rr,
	input wire rv
);
	initial
	begin
		{awa, awv, wd, wv, ara, arv} <= 'h0;
	end
	// ready signals are read before the edge's updates land
	// valid is only lowered while still up, so a following call
	// never assigns it twice in one time step
	task wr(input [7:0] a, input [7:0] d, output [1:0] r);
	begin
		awa <= a;
		wd <= {24'h0, d};
		awv <= 1'b1;
		wv <= 1'b1;
		do
		begin
			@(posedge mclk);
			if (awv && awr)
				awv <= 1'b0;
			if (wv && wr_r)
				wv <= 1'b0;
		end
		while (!bv);
		r = br;
	end
	endtask
	task rd(input [7:0] a, output [9:0] q);
	begin
		ara <= a;
		arv <= 1'b1;
		do
		begin
			@(posedge mclk);
			if (arv && arr)
				arv <= 1'b0;
		end
		while (!rv);
		q = {rr, rdat[7:0]};
	end
	endtask
endmodule

// File: bench/tb_idp_pointer_unit.sv
// self-checking bench for the pointer unit
`timescale 1ns/1ps
module tb_idp_pointer_unit;
	reg mclk = 1'b0;
	reg rst = 1'b1;
	reg ext_reset_pin_n = 1'b1;
	reg wdt_timeout = 1'b0;
	wire [7:0] awa, ara;
	wire [31:0] wd, rdat;
	wire [1:0] rr, br;
	wire awv, awr, wv, wr_r, bv, arv, arr, rv;
	integer failures = 0;
	integer checks = 0;
	reg [9:0] q;
	reg [1:0] r;
	always #25 mclk = ~mclk;
	idp_pointer_unit idp_pointer_unit_inst (.mclk(mclk), .rst(rst),
		.ext_reset_pin_n(ext_reset_pin_n), .wdt_timeout(wdt_timeout),
		.s_axi_awaddr(awa), .s_axi_awvalid(awv), .s_axi_awready(awr),
		.s_axi_wdata(wd), .s_axi_wstrb(4'hf), .s_axi_wvalid(wv),
		.s_axi_wready(wr_r), .s_axi_bresp(br), .s_axi_bvalid(bv),
		.s_axi_bready(1'b1), .s_axi_araddr(ara), .s_axi_arvalid(arv),
		.s_axi_arready(arr), .s_axi_rdata(rdat), .s_axi_rresp(rr),
		.s_axi_rvalid(rv), .s_axi_rready(1'b1));
	idp_core idp_core_inst (.mclk(mclk), .awa(awa), .awv(awv), .awr(awr),
		.wd(wd), .wv(wv), .wr_r(wr_r), .bv(bv), .br(br),
		.ara(ara), .arv(arv),
		.arr(arr), .rdat(rdat), .rr(rr), .rv(rv));
	task chk(input [9:0] g, input [9:0] e);
	begin
		checks = checks + 1;
		if (g !== e)
		begin
			failures = failures + 1;
			$display("CHECK FAILED %0t got %h exp %h", $time, g, e);
		end
	end
	endtask
	task chk_resp(input [1:0] g, input [1:0] e);
	begin
		checks = checks + 1;
		if (g !== e)
		begin
			failures = failures + 1;
			$display("CHECK FAILED %0t bresp %h exp %h", $time, g, e);
		end
	end
	endtask
	task rc(input [7:0] a, input [9:0] e);
	begin
		idp_core_inst.rd(a, q);
		chk(q, e);
	end
	endtask
	task w(input [7:0] a, input [7:0] d, input [1:0] e);
	begin
		idp_core_inst.wr(a, d, r);
		chk_resp(r, e);
	end
	endtask
	task close_out;
	begin
		$display("checks %0d failures %0d", checks, failures);
		if (failures == 0 && checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	end
	endtask
	initial
	begin
		#(50 * 3000);
		failures = failures + 1;
		close_out;
	end
	initial
	begin
		repeat (4) @(posedge mclk);
		rst <= 1'b0;
		@(posedge mclk);
		rc(8'h0c, 10'h000);
		rc(8'h1c, 10'h000);
		w(8'h08, 8'hff, 2'h0);
		w(8'h0c, 8'h03, 2'h0);
		w(8'h18, 8'h10, 2'h0);
		// pointer 1 at 0x3ff: the bump must carry into the high nibble
		w(8'h4c, 8'ha5, 2'h0);
		rc(8'h0c, 10'h004);
		rc(8'h40, 10'h0a5);
		rc(8'h48, 10'h0a5);
		rc(8'h08, 10'h0ff);
		w(8'h44, 8'h5a, 2'h0);
		rc(8'h48, 10'h0a5);
		rc(8'h40, 10'h05a);
		rc(8'h0c, 10'h003);
		w(8'h10, 8'h0f, 2'h0);
		w(8'h14, 8'h04, 2'h0);
		w(8'h60, 8'h77, 2'h0);
		rc(8'h50, 10'h077);
		rc(8'h08, 10'h0ff);
		rc(8'h80, 10'h200);
		rc(8'h54, 10'h200);
		// pointer 0: post-decrement write, pre-increment read back
		w(8'h00, 8'h20, 2'h0);
		w(8'h04, 8'h01, 2'h0);
		w(8'h28, 8'h3c, 2'h0);
		rc(8'h00, 10'h01f);
		rc(8'h2c, 10'h03c);
		rc(8'h00, 10'h020);
		// refused writes answer with an error and move nothing
		w(8'h34, 8'h99, 2'h2);
		w(8'h80, 8'h99, 2'h2);
		rc(8'h00, 10'h020);
		rc(8'h04, 10'h001);
		w(8'h1c, 8'h05, 2'h0);
		wdt_timeout <= 1'b1;
		@(posedge mclk);
		wdt_timeout <= 1'b0;
		rc(8'h14, 10'h000);
		rc(8'h10, 10'h00f);
		rc(8'h1c, 10'h000);
		w(8'h0c, 8'h02, 2'h0);
		ext_reset_pin_n <= 1'b0;
		repeat (4) @(posedge mclk);
		ext_reset_pin_n <= 1'b1;
		repeat (3) @(posedge mclk);
		rc(8'h0c, 10'h000);
		rc(8'h18, 10'h010);
		close_out;
	end
endmodule

// File: hdl/idp_map.vh
// register map, field positions, reset values and mode codes of the pointer unit
`ifndef IDP_MAP_VH
`define IDP_MAP_VH

// byte offsets of the stored registers, one aligned word each
`define IDP_OFF_PTR0_LOW 8'h00
`define IDP_OFF_PTR0_HIGH 8'h04
`define IDP_OFF_PTR1_LOW 8'h08
`define IDP_OFF_PTR1_HIGH 8'h0c
`define IDP_OFF_PTR2_LOW 8'h10
`define IDP_OFF_PTR2_HIGH 8'h14
`define IDP_OFF_WORKING 8'h18
`define IDP_OFF_BANK 8'h1c

// operand windows: base + pointer * stride + mode * 4
`define IDP_OFF_OP_BASE 8'h20
`define IDP_OFF_OP_STRIDE 8'h20

// word index of the stored registers (address bits 6:2)
`define IDP_IDX_WORKING 5'h06
`define IDP_IDX_BANK 5'h07

// address fields
`define IDP_ADDR_TOP 7
`define IDP_PTR_SEL_MSB 6
`define IDP_PTR_SEL_LSB 5
`define IDP_MODE_MSB 4
`define IDP_MODE_LSB 2

// operand modes inside one window
`define IDP_MODE_PLAIN 3'h0
`define IDP_MODE_POST_INCREMENT_OPERAND 3'h1
`define IDP_MODE_POST_DECREMENT_OPERAND 3'h2
`define IDP_MODE_PRE_INCREMENT_OPERAND 3'h3
`define IDP_MODE_INDEXED 3'h4

// widths and reset values
`define IDP_PTR_W 12
`define IDP_HIGH_W 4
`define IDP_RST_PTR_HIGH 4'h0
`define IDP_RST_BANK 4'h0

// AXI responses
`define IDP_RESP_OKAY 2'h0
`define IDP_RESP_SLVERR 2'h2

`endif

// File: hdl/idp_pointer_unit.v
// indirect data-memory pointer unit with AXI4-Lite register access
//
// What this block does
// - operand access uses current combined pointer value
// - operand locations store nothing, redirect to memory
// - pre-increment bumps pointer, then accesses memory
// - indexed access uses pointer plus working register
// - high byte four bits, cleared by every reset
// - low byte undefined at power-up, else kept
// - pin and watchdog resets keep retained values
//
// Design decisions made here: the AXI4-Lite interface to the registers and the register offsets.
`timescale 1ns/1ps
`include "idp_map.vh"

module idp_pointer_unit #(
	parameter MEM_DEPTH = 4096
)(
	input wire mclk,
	input wire rst,
	input wire ext_reset_pin_n,
	input wire wdt_timeout,
	input wire [7:0] s_axi_awaddr,
	input wire s_axi_awvalid,
	output wire s_axi_awready,
	input wire [31:0] s_axi_wdata,
	input wire [3:0] s_axi_wstrb,
	input wire s_axi_wvalid,
	output wire s_axi_wready,
	output wire [1:0] s_axi_bresp,
	output wire s_axi_bvalid,
	input wire s_axi_bready,
	input wire [7:0] s_axi_araddr,
	input wire s_axi_arvalid,
	output wire s_axi_arready,
	output wire [31:0] s_axi_rdata,
	output wire [1:0] s_axi_rresp,
	output wire s_axi_rvalid,
	input wire s_axi_rready
);

	// data memory reached only through the operand windows
	reg [7:0] mem [0:MEM_DEPTH-1];

	reg pin_s1_ff;
	reg pin_s2_ff;
	reg aw_full_ff;
	reg [7:0] aw_addr_ff;
	reg w_full_ff;
	reg [7:0] w_data_ff;
	reg w_strb_ff;
	reg bvalid_ff;
	reg [1:0] bresp_ff;
	reg rvalid_ff;
	reg [1:0] rresp_ff;
	reg [7:0] rdata_ff;
	reg [7:0] working_ff;
	reg [3:0] bank_ff;

	wire soft_rst;
	wire wr_go;
	wire rd_go;
	wire wr_ok;
	wire rd_ok;
	wire wr_is_op;
	wire rd_is_op;
	wire reg_wr;
	wire [4:0] w_idx;
	wire [4:0] r_idx;
	wire op_go;
	wire op_write;
	wire [1:0] op_ptr;
	wire [2:0] op_mode;
	wire [3*`IDP_PTR_W-1:0] ptr_flat;
	wire [`IDP_PTR_W-1:0] cur_ptr;
	reg [`IDP_PTR_W-1:0] nxt_ptr;
	reg [`IDP_PTR_W-1:0] acc_addr;
	reg [7:0] reg_rdata;

	// map check: bit 7 clear, and inside a window only modes 0..4 exist
	function addr_ok;
		input [7:0] a;
		begin
			addr_ok = !a[`IDP_ADDR_TOP] &&
				(a[`IDP_PTR_SEL_MSB:`IDP_PTR_SEL_LSB] == 2'h0 ||
				a[`IDP_MODE_MSB:`IDP_MODE_LSB] <= `IDP_MODE_INDEXED);
		end
	endfunction

	// external reset pin is asynchronous to mclk
	always @(posedge mclk)
	begin
		if (rst)
		begin
			pin_s1_ff <= 1'b1;
			pin_s2_ff <= 1'b1;
		end
		else
		begin
			pin_s1_ff <= ext_reset_pin_n;
			pin_s2_ff <= pin_s1_ff;
		end
	end

	// pin and watchdog resets only clear the reset-defined fields
	assign soft_rst = !pin_s2_ff | wdt_timeout;

	// write channel: address and data caught independently
	assign s_axi_awready = !aw_full_ff;
	assign s_axi_wready = !w_full_ff;
	assign s_axi_bvalid = bvalid_ff;
	assign s_axi_bresp = bresp_ff;
	assign wr_go = aw_full_ff & w_full_ff & !bvalid_ff;
	assign wr_ok = addr_ok(aw_addr_ff);
	assign w_idx = aw_addr_ff[6:2];
	assign wr_is_op = aw_addr_ff[`IDP_PTR_SEL_MSB:`IDP_PTR_SEL_LSB] != 2'h0;

	always @(posedge mclk)
	begin
		if (rst)
		begin
			aw_full_ff <= 1'b0;
			aw_addr_ff <= 8'h00;
			w_full_ff <= 1'b0;
			w_data_ff <= 8'h00;
			w_strb_ff <= 1'b0;
			bvalid_ff <= 1'b0;
			bresp_ff <= `IDP_RESP_OKAY;
		end
		else
		begin
			if (s_axi_awvalid && !aw_full_ff)
			begin
				aw_full_ff <= 1'b1;
				aw_addr_ff <= s_axi_awaddr;
			end
			else if (wr_go)
				aw_full_ff <= 1'b0;
			if (s_axi_wvalid && !w_full_ff)
			begin
				w_full_ff <= 1'b1;
				w_data_ff <= s_axi_wdata[7:0];
				w_strb_ff <= s_axi_wstrb[0];
			end
			else if (wr_go)
				w_full_ff <= 1'b0;
			if (wr_go)
			begin
				bvalid_ff <= 1'b1;
				bresp_ff <= wr_ok ? `IDP_RESP_OKAY : `IDP_RESP_SLVERR;
			end
			else if (s_axi_bready)
				bvalid_ff <= 1'b0;
		end
	end

	// read channel stalls while a write executes, so only one
	// operand access can move a pointer in any cycle
	assign s_axi_arready = !rvalid_ff & !wr_go;
	assign rd_go = s_axi_arvalid & s_axi_arready;
	assign rd_ok = addr_ok(s_axi_araddr);
	assign r_idx = s_axi_araddr[6:2];
	assign rd_is_op =
		s_axi_araddr[`IDP_PTR_SEL_MSB:`IDP_PTR_SEL_LSB] != 2'h0;
	assign s_axi_rvalid = rvalid_ff;
	assign s_axi_rresp = rresp_ff;
	assign s_axi_rdata = {24'h000000, rdata_ff};

	// lane 0 carries the byte; a write without it has no effect at all
	assign reg_wr = wr_go & w_strb_ff & wr_ok & !wr_is_op;
	assign op_go = (wr_go & w_strb_ff & wr_ok & wr_is_op) |
		(rd_go & rd_ok & rd_is_op);
	assign op_write = wr_go;
	assign op_ptr = wr_go ?
		aw_addr_ff[`IDP_PTR_SEL_MSB:`IDP_PTR_SEL_LSB] - 2'h1 :
		s_axi_araddr[`IDP_PTR_SEL_MSB:`IDP_PTR_SEL_LSB] - 2'h1;
	assign op_mode = wr_go ? aw_addr_ff[`IDP_MODE_MSB:`IDP_MODE_LSB] :
		s_axi_araddr[`IDP_MODE_MSB:`IDP_MODE_LSB];

	assign cur_ptr = ptr_flat[op_ptr*`IDP_PTR_W +: `IDP_PTR_W];

	// pointers wrap within 12 bits in both directions
	always @*
	begin
		acc_addr = cur_ptr;
		nxt_ptr = cur_ptr;
		case (op_mode)
			`IDP_MODE_POST_INCREMENT_OPERAND:
				nxt_ptr = cur_ptr + 12'h001;
			`IDP_MODE_POST_DECREMENT_OPERAND:
				nxt_ptr = cur_ptr - 12'h001;
			`IDP_MODE_PRE_INCREMENT_OPERAND:
			begin
				acc_addr = cur_ptr + 12'h001;
				nxt_ptr = cur_ptr + 12'h001;
			end
			`IDP_MODE_INDEXED:
				acc_addr = cur_ptr + {4'h0, working_ff};
			default:
				nxt_ptr = cur_ptr;
		endcase
	end

	genvar g;
	generate
		for (g = 0; g < 3; g = g + 1)
		begin : gp
			// integer-wide so the loop index is never truncated
			localparam integer SEL = g;
			localparam integer LOW_IDX = 2 * g;
			localparam integer HIGH_IDX = 2 * g + 1;
			reg [`IDP_HIGH_W-1:0] high_ff;
			reg [7:0] low_ff;

			assign ptr_flat[g*`IDP_PTR_W +: `IDP_PTR_W] = {high_ff, low_ff};

			always @(posedge mclk)
			begin
				if (rst || soft_rst)
					high_ff <= `IDP_RST_PTR_HIGH;
				else if (reg_wr && w_idx == HIGH_IDX)
					high_ff <= w_data_ff[`IDP_HIGH_W-1:0];
				else if (op_go && op_ptr == SEL)
					high_ff <= nxt_ptr[`IDP_PTR_W-1:8];
			end

			// no reset: undefined at power-up, kept over other resets
			always @(posedge mclk)
			begin
				if (reg_wr && w_idx == LOW_IDX)
					low_ff <= w_data_ff;
				else if (op_go && op_ptr == SEL)
					low_ff <= nxt_ptr[7:0];
			end
		end
	endgenerate

	// working register keeps its value over every reset kind
	always @(posedge mclk)
	begin
		if (reg_wr && w_idx == `IDP_IDX_WORKING)
			working_ff <= w_data_ff;
	end

	always @(posedge mclk)
	begin
		if (rst || soft_rst)
			bank_ff <= `IDP_RST_BANK;
		else if (reg_wr && w_idx == `IDP_IDX_BANK)
			bank_ff <= w_data_ff[3:0];
	end

	always @(posedge mclk)
	begin
		if (op_go && op_write)
			mem[acc_addr] <= w_data_ff;
	end

	always @*
	begin
		reg_rdata = 8'h00;
		case (r_idx)
			5'h00:
				reg_rdata = gp[0].low_ff;
			5'h01:
				reg_rdata = {4'h0, gp[0].high_ff};
			5'h02:
				reg_rdata = gp[1].low_ff;
			5'h03:
				reg_rdata = {4'h0, gp[1].high_ff};
			5'h04:
				reg_rdata = gp[2].low_ff;
			5'h05:
				reg_rdata = {4'h0, gp[2].high_ff};
			`IDP_IDX_WORKING:
				reg_rdata = working_ff;
			`IDP_IDX_BANK:
				reg_rdata = {4'h0, bank_ff};
			default:
				reg_rdata = 8'h00;
		endcase
	end

	always @(posedge mclk)
	begin
		if (rst)
		begin
			rvalid_ff <= 1'b0;
			rresp_ff <= `IDP_RESP_OKAY;
			rdata_ff <= 8'h00;
		end
		else if (rd_go)
		begin
			rvalid_ff <= 1'b1;
			rresp_ff <= rd_ok ? `IDP_RESP_OKAY : `IDP_RESP_SLVERR;
			if (!rd_ok)
				rdata_ff <= 8'h00;
			else if (rd_is_op)
				rdata_ff <= mem[acc_addr];
			else
				rdata_ff <= reg_rdata;
		end
		else if (s_axi_rready)
			rvalid_ff <= 1'b0;
	end

endmodule
